/* File: logic/afx_pkg.sv */
// Purpose: shared constants and carriers of the oversampling filter block
// Assumes: twelve-bit converter results, two filter instances
// Notes: offsets are word byte addresses on the plain register port
package afx_pkg;

	localparam int AFX_NUM_FILT   = 2;
	localparam int AFX_NUM_IN     = 8;
	localparam int AFX_SAMPLE_W   = 12;
	localparam int AFX_ACC_W      = 20;
	localparam int AFX_RES_W      = 16;
	localparam int AFX_ADDR_W     = 8;
	localparam int AFX_CNT_W      = 9;

	// register offsets
	localparam logic [7:0] AFX_OFS_FILT0 = 8'h00;
	localparam logic [7:0] AFX_OFS_FILT1 = 8'h04;
	localparam logic [7:0] AFX_OFS_CTL2  = 8'h08;
	localparam logic [7:0] AFX_OFS_GCFG  = 8'h0c;

	// filter_control_and_result fields
	localparam int AFX_B_ENABLE   = 31;
	localparam int AFX_B_RES16    = 30;
	localparam int AFX_B_MODE     = 29;
	localparam int AFX_B_RATIO_HI = 28;
	localparam int AFX_B_RATIO_LO = 26;
	localparam int AFX_B_GIRQ     = 25;
	localparam int AFX_B_READY    = 24;
	localparam int AFX_B_SEL_HI   = 20;
	localparam int AFX_B_SEL_LO   = 16;
	localparam int AFX_B_RES_HI   = 15;

	// converter_control_two and global config fields
	localparam int AFX_B_SAMPLE_TIME_COUNT_HI  = 25;
	localparam int AFX_B_SAMPLE_TIME_COUNT_LO  = 16;
	localparam int AFX_B_FRACTIONAL_FORMAT    = 0;

	localparam logic [31:0] AFX_RST_FILT = 32'h0000_0000;
	localparam logic [9:0]  AFX_RST_SAMPLE_TIME_COUNT = 10'h000;
	localparam logic        AFX_RST_FRAC = 1'b0;

	localparam logic AFX_MODE_OVERSAMPLE = 1'b0;
	localparam logic AFX_MODE_AVERAGE    = 1'b1;

	typedef struct packed {
		logic       enable;
		logic       res16;
		logic       mode;
		logic [2:0] ratio;
		logic       girq;
		logic [4:0] sel;
	} afx_cfg_t;

	typedef struct packed {
		logic                    valid;
		logic [4:0]              src;
		logic [AFX_SAMPLE_W-1:0] data;
	} afx_conv_t;

endpackage

/* File: logic/afx_filter.sv */
// Purpose: one accumulate-and-decimate filter channel
// Assumes: results of the selected input arrive as one-cycle valid pulses
// Notes: conversion pacing is left to the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module afx_filter
	import afx_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// configuration
	input  wire afx_pkg::afx_cfg_t      cfg,
	input  wire logic                   frac,
	input  wire logic                   allow,
	// converter side
	input  wire logic                   trig,
	input  wire afx_pkg::afx_conv_t     conv,
	// status
	output logic                        busy,
	output logic                        pending,
	output logic                        force_trig,
	output logic                        done,
	output logic [AFX_RES_W-1:0]        result_q
);
	import afx_pkg::*;

	typedef enum logic [2:0] {
		AFX_S_IDLE = 3'b001,
		AFX_S_HOLD = 3'b010,
		AFX_S_RUN  = 3'b100
	} afx_state_t;

	afx_state_t             state_q;
	logic [AFX_ACC_W-1:0]   acc_q;
	logic [AFX_CNT_W-1:0]   left_q;
	logic [3:0]             log2_n;
	logic                   take;
	logic                   last;
	logic [AFX_ACC_W-1:0]   sum;
	logic [AFX_ACC_W-1:0]   os_val;
	logic [AFX_ACC_W-1:0]   av_val;

	// 0..3 give 4,16,64,256; upper codes give 2,8,32,128 for averaging use
	function automatic logic [3:0] afx_log2(input logic [2:0] r);
		afx_log2 = r[2] ? {r[1:0], 1'b0} + 4'h1 : {r[1:0], 1'b0} + 4'h2;
	endfunction

	assign log2_n = afx_log2(cfg.ratio);
	assign take   = (state_q == AFX_S_RUN) && conv.valid && (conv.src == cfg.sel);
	assign last   = take && (left_q == 9'h001);
	assign sum    = acc_q + AFX_ACC_W'(conv.data);
	// extra bits = half the ratio exponent, so drop the other half
	assign os_val = sum >> (log2_n - (log2_n >> 1));
	assign av_val = sum >> log2_n;

	assign busy       = (state_q == AFX_S_RUN);
	assign pending    = (state_q == AFX_S_HOLD);
	assign force_trig = busy;

	always_ff @(posedge clk) begin
		if (!rst_n || !cfg.enable) begin
			state_q <= AFX_S_IDLE;
		end else begin
			unique case (state_q)
				AFX_S_IDLE: begin
					if (trig) begin
						state_q <= allow ? AFX_S_RUN : AFX_S_HOLD;
					end
				end
				AFX_S_HOLD: begin
					if (allow) begin
						state_q <= AFX_S_RUN;
					end
				end
				AFX_S_RUN: begin
					if (last) begin
						state_q <= AFX_S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q  <= '0;
			left_q <= '0;
		end else if (state_q != AFX_S_RUN) begin
			acc_q  <= '0;
			left_q <= AFX_CNT_W'(10'h001 << log2_n);
		end else if (take) begin
			acc_q  <= sum;
			left_q <= left_q - 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_q <= '0;
			done     <= 1'b0;
		end else begin
			done <= last;
			if (last) begin
				if (cfg.mode == AFX_MODE_OVERSAMPLE) begin
					result_q <= os_val[AFX_RES_W-1:0];
				end else if (frac && cfg.res16) begin
					result_q <= {av_val[AFX_SAMPLE_W-1:0], 4'h0};
				end else begin
					result_q <= av_val[AFX_RES_W-1:0];
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: logic/afx_top.sv */
// Purpose: two-channel oversampling and averaging filter beside a shared converter
// Assumes: lower input number means higher conversion priority
// Notes: timing of each sample (sample time plus conversion) is paced by the converter
// Function
// - Two independent filters, each with own configuration, result and ready flag.
// - Each filter is an accumulator followed by a decimator acting as low-pass.
// - Ratios 4,16,64,256 give one to four extra bits, 13 to 16 bits.
// - Averaging mode divides the accumulated sum by the sample count.
// - Only shared-class inputs 0 to 7 may feed a filter.
// - During a burst higher-priority inputs proceed, lower ones are held pending.
// - Ratio field at bits 28:26 selects number of samples per result.
// - Bit 29 selects mode; zero means oversampling.
// - Bit 30 sets averaged output resolution in fractional format.
// - Burst samples use the ten-bit sample time in bits 25:16 of control two.
// - Input select at bits 20:16 names the oversampled input.
// - Bit 25 ORs the completion event into the global converter interrupt.
// - Bit 31 enables the filter; cleared, it neither accumulates nor retriggers.
// - Input trigger clears the accumulator and starts the first conversion.
// - During a burst trigger is forced level-sensitive and held asserted.
// - Sample spacing is sample time plus conversion time; retriggers reuse it.
// - At the end the 16-bit result lands in 15:0 and ready bit 24 sets.
// - Burst blocks lower shared and dedicated-scan triggers; software avoids higher ones.
// - With two filters the higher-priority input finishes its burst first.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module afx_top
	import afx_pkg::*;
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// register port
	input  wire logic [afx_pkg::AFX_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [31:0]                        reg_rdata,
	// converter sequencing side
	input  wire logic [afx_pkg::AFX_NUM_IN-1:0] in_trig,
	input  wire afx_pkg::afx_conv_t            conv,
	output logic [afx_pkg::AFX_NUM_IN-1:0]     force_trig,
	output logic [afx_pkg::AFX_NUM_IN-1:0]     force_level,
	output logic [afx_pkg::AFX_NUM_IN-1:0]     hold_shared,
	output logic                               hold_scan,
	output logic [9:0]                         sample_time_count,
	output logic                               fractional_format,
	// global interrupt contribution
	output logic                               global_irq_evt
);
	import afx_pkg::*;

	afx_cfg_t                 cfg_q      [AFX_NUM_FILT];
	logic                     ready_q    [AFX_NUM_FILT];
	logic [AFX_RES_W-1:0]     result     [AFX_NUM_FILT];
	logic                     busy       [AFX_NUM_FILT];
	logic                     pend       [AFX_NUM_FILT];
	logic                     frc        [AFX_NUM_FILT];
	logic                     done       [AFX_NUM_FILT];
	logic                     allow      [AFX_NUM_FILT];
	logic                     trig       [AFX_NUM_FILT];
	logic                     sel_ok     [AFX_NUM_FILT];
	logic [AFX_NUM_IN-1:0]    below_mask [AFX_NUM_FILT];
	logic [AFX_NUM_IN-1:0]    own_mask   [AFX_NUM_FILT];
	logic [9:0]               sample_time_count_q;
	logic                     frac_q;
	logic [31:0]              rdata_d;
	logic [AFX_NUM_FILT-1:0]  irq_vec;

	// one-hot of a valid input number, zero for numbers above the shared range
	function automatic logic [AFX_NUM_IN-1:0] afx_onehot(input logic [4:0] s);
		afx_onehot = (s < 5'(AFX_NUM_IN)) ? AFX_NUM_IN'(1) << s[2:0] : '0;
	endfunction

	// every input with a higher number, i.e. lower priority
	function automatic logic [AFX_NUM_IN-1:0] afx_below(input logic [4:0] s);
		afx_below = (s < 5'(AFX_NUM_IN)) ? ~((AFX_NUM_IN'(2) << s[2:0]) - AFX_NUM_IN'(1)) : '0;
	endfunction

	function automatic logic [7:0] afx_filt_ofs(input int i);
		afx_filt_ofs = (i == 0) ? AFX_OFS_FILT0 : AFX_OFS_FILT1;
	endfunction

	function automatic afx_cfg_t afx_cfg_of(input logic [31:0] w);
		afx_cfg_t c;
		c.enable = w[AFX_B_ENABLE];
		c.res16  = w[AFX_B_RES16];
		c.mode   = w[AFX_B_MODE];
		c.ratio  = w[AFX_B_RATIO_HI:AFX_B_RATIO_LO];
		c.girq   = w[AFX_B_GIRQ];
		c.sel    = w[AFX_B_SEL_HI:AFX_B_SEL_LO];
		afx_cfg_of = c;
	endfunction

	function automatic logic [31:0] afx_word_of(input afx_cfg_t c, input logic rdy,
	                                            input logic [AFX_RES_W-1:0] r);
		logic [31:0] w;
		w                                 = '0;
		w[AFX_B_ENABLE]                   = c.enable;
		w[AFX_B_RES16]                    = c.res16;
		w[AFX_B_MODE]                     = c.mode;
		w[AFX_B_RATIO_HI:AFX_B_RATIO_LO]  = c.ratio;
		w[AFX_B_GIRQ]                     = c.girq;
		w[AFX_B_READY]                    = rdy;
		w[AFX_B_SEL_HI:AFX_B_SEL_LO]      = c.sel;
		w[AFX_B_RES_HI:0]                 = r;
		afx_word_of = w;
	endfunction

	// converter_control_two sample time and global fractional format
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_time_count_q <= AFX_RST_SAMPLE_TIME_COUNT;
			frac_q <= AFX_RST_FRAC;
		end else if (reg_wr) begin
			if (reg_addr == AFX_OFS_CTL2) begin
				sample_time_count_q <= reg_wdata[AFX_B_SAMPLE_TIME_COUNT_HI:AFX_B_SAMPLE_TIME_COUNT_LO];
			end
			if (reg_addr == AFX_OFS_GCFG) begin
				frac_q <= reg_wdata[AFX_B_FRACTIONAL_FORMAT];
			end
		end
	end

	// first and retriggered samples alike use this sample time
	assign sample_time_count = sample_time_count_q;
	assign fractional_format = frac_q;

	genvar gi;
	generate
		for (gi = 0; gi < AFX_NUM_FILT; gi++) begin : g_filt

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					cfg_q[gi] <= afx_cfg_of(AFX_RST_FILT);
				end else if (reg_wr && reg_addr == afx_filt_ofs(gi)) begin
					cfg_q[gi] <= afx_cfg_of(reg_wdata);
				end
			end

			// ready is cleared by reading the register; a completion in the
			// same cycle as the read wins so no result is lost
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					ready_q[gi] <= 1'b0;
				end else if (done[gi]) begin
					ready_q[gi] <= 1'b1;
				end else if (reg_rd && reg_addr == afx_filt_ofs(gi)) begin
					ready_q[gi] <= 1'b0;
				end
			end

			assign own_mask[gi]   = afx_onehot(cfg_q[gi].sel);
			assign sel_ok[gi]     = |own_mask[gi];
			assign trig[gi]       = sel_ok[gi] && |(in_trig & own_mask[gi]);
			assign below_mask[gi] = (busy[gi] || pend[gi]) ? afx_below(cfg_q[gi].sel) : '0;
			assign irq_vec[gi]    = done[gi] && cfg_q[gi].girq;

			afx_filter u_filt (
				.clk        (clk),
				.rst_n      (rst_n),
				.cfg        (cfg_q[gi]),
				.frac       (frac_q),
				.allow      (allow[gi]),
				.trig       (trig[gi]),
				.conv       (conv),
				.busy       (busy[gi]),
				.pending    (pend[gi]),
				.force_trig (frc[gi]),
				.done       (done[gi]),
				.result_q   (result[gi])
			);
		end
	endgenerate

	// shared converter arbitration between the two filters: a filter whose
	// input ranks lower waits while the other one runs; on equal inputs the
	// first instance keeps precedence and may start even while the second one runs
	always_comb begin
		// a trigger that reaches both filters at one edge must not start two
		// bursts: the other filter's trigger counts as a claim on the converter
		allow[0] = !(busy[1] && (cfg_q[1].sel < cfg_q[0].sel)) &&
		           !(trig[1] && cfg_q[1].enable && (cfg_q[1].sel < cfg_q[0].sel));
		allow[1] = !(busy[0] && (cfg_q[0].sel <= cfg_q[1].sel)) &&
		           !(pend[0] && (cfg_q[0].sel <= cfg_q[1].sel)) &&
		           !(trig[0] && cfg_q[0].enable && (cfg_q[0].sel <= cfg_q[1].sel));
	end

	// retrigger requests and blocking masks towards the sequencer
	always_comb begin
		force_trig  = '0;
		hold_shared = '0;
		hold_scan   = 1'b0;
		for (int i = 0; i < AFX_NUM_FILT; i++) begin
			if (frc[i]) begin
				force_trig = force_trig | own_mask[i];
			end
			hold_shared = hold_shared | below_mask[i];
			hold_scan   = hold_scan | busy[i] | pend[i];
		end
		// an input under its own burst must never be held off by the other filter
		for (int i = 0; i < AFX_NUM_FILT; i++) begin
			if (busy[i]) begin
				hold_shared = hold_shared & ~own_mask[i];
			end
		end
	end

	// level sensitivity is forced exactly while the retrigger is held
	assign force_level = force_trig;

	// one pulse per cycle in which a filter that is included globally completes
	assign global_irq_evt = |irq_vec;

	// read mux; unmapped offsets read as zero
	always_comb begin
		rdata_d = '0;
		unique case (reg_addr)
			AFX_OFS_FILT0: rdata_d = afx_word_of(cfg_q[0], ready_q[0], result[0]);
			AFX_OFS_FILT1: rdata_d = afx_word_of(cfg_q[1], ready_q[1], result[1]);
			AFX_OFS_CTL2: begin
				rdata_d[AFX_B_SAMPLE_TIME_COUNT_HI:AFX_B_SAMPLE_TIME_COUNT_LO] = sample_time_count_q;
			end
			AFX_OFS_GCFG: begin
				rdata_d[AFX_B_FRACTIONAL_FORMAT] = frac_q;
			end
			default: rdata_d = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule
`default_nettype wire

/* File: dv/afx_props.sv */
// Purpose: port checks of the two-channel filter block
// Assumes: lower input number has higher priority
// Notes: attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
module afx_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// converter side
	input wire logic [7:0]  force_trig,
	input wire logic [7:0]  force_level,
	input wire logic [7:0]  hold_shared,
	input wire logic        hold_scan,
	input wire logic [9:0]  sample_time_count,
	input wire logic        fractional_format,
	input wire logic        global_irq_evt
);
	import afx_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_start;
		$rose(force_trig[0]);
	endsequence
	sequence s_wr_ctl2;
		reg_wr && reg_addr == AFX_OFS_CTL2;
	endsequence
	AST_LEVEL_FORCED: assert property (force_level == force_trig) else $error("level mode not forced");
	AST_START_HOLDS: assert property (s_start |-> hold_scan && hold_shared[7:1] == 7'h7f)
		else $error("lower inputs not held");
	AST_SCAN_BLOCK: assert property (|force_trig |-> hold_scan) else $error("scan not blocked");
	AST_ONE_BURST: assert property ($onehot0(force_trig)) else $error("two bursts at once");
	AST_IRQ_AT_END: assert property (global_irq_evt |-> |($past(force_trig) & ~force_trig))
		else $error("irq without burst end");
	AST_IRQ_PULSE: assert property (global_irq_evt |=> !global_irq_evt) else $error("irq too long");
	AST_SAMPLE_TIME_COUNT_COPY: assert property (s_wr_ctl2 |=> sample_time_count == $past(reg_wdata[25:16]))
		else $error("sample time not copied");
	AST_FRAC_COPY: assert property (reg_wr && reg_addr == AFX_OFS_GCFG |=> fractional_format == $past(reg_wdata[0]))
		else $error("format not copied");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data stands");
endmodule
bind afx_top afx_props u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .force_trig(force_trig), .force_level(force_level),
	.hold_shared(hold_shared), .hold_scan(hold_scan), .sample_time_count(sample_time_count),
	.fractional_format(fractional_format), .global_irq_evt(global_irq_evt));
`default_nettype wire

/* File: dv/afx_seq_model.sv */
// Purpose: converter sequencer that serves forced filter triggers
// Assumes: conversion takes a fixed number of cycles
// Notes: idle result lines show inverted data, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module afx_seq_model #(
	parameter int CONV_T = 2
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// filter side
	input  wire logic [7:0]          force_trig,
	input  wire logic [9:0]          sample_time_count,
	input  wire logic [11:0]         smp,
	output var  afx_pkg::afx_conv_t  conv
);
	import afx_pkg::*;
	logic [10:0] cnt_q;
	logic [10:0] period_m1;
	logic [2:0]  idx;
	assign period_m1 = 11'(sample_time_count) + 11'(CONV_T - 1);
	// only the highest-priority forced input gets the converter
	always_comb begin
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (force_trig[i]) begin
				idx = 3'(i);
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || force_trig == 8'h00) begin
			cnt_q <= 11'h000;
			conv  <= '{valid: 1'b0, src: 5'h1f, data: ~smp};
		end else if (cnt_q == period_m1) begin
			cnt_q <= 11'h000;
			conv  <= '{valid: 1'b1, src: {2'b00, idx}, data: smp};
		end else begin
			cnt_q <= cnt_q + 11'h001;
			conv  <= '{valid: 1'b0, src: ~{2'b00, idx}, data: ~smp};
		end
	end
endmodule
`default_nettype wire

/* File: dv/afx_tb_top.sv */
// Purpose: self-checking bench of the filter block
// Assumes: sample time of one cycle plus two conversion cycles
// Notes: table rows cover every ratio code and both modes
`timescale 1ns/10ps
`default_nettype none
module afx_tb_top;
	import afx_pkg::*;
	typedef struct packed {
		logic [2:0]  ratio;
		logic        mode;
		logic        res16;
		logic        girq;
		logic [11:0] v;
	} afx_row_t;
	logic        clk         = 1'b0;
	logic        rst_n       = 1'b0;
	logic [7:0]  reg_addr    = 8'h00;
	logic [31:0] reg_wdata   = 32'h0;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic [7:0]  in_trig     = 8'h00;
	logic [11:0] smp         = 12'h000;
	logic [31:0] reg_rdata, rdat, w;
	logic [7:0]  force_trig, force_level, hold_shared;
	logic        hold_scan, fractional_format, global_irq_evt;
	logic [9:0]  sample_time_count;
	afx_conv_t   conv;
	int          mismatches  = 0;
	int          checked     = 0;
	int          nlog [8]    = '{2, 4, 6, 8, 1, 3, 5, 7};
	afx_row_t    rows [10];
	always #12.5 clk = ~clk;
	afx_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_trig(in_trig), .conv(conv), .force_trig(force_trig),
		.force_level(force_level), .hold_shared(hold_shared), .hold_scan(hold_scan),
		.sample_time_count(sample_time_count), .fractional_format(fractional_format),
		.global_irq_evt(global_irq_evt));
	afx_seq_model u_seq (.clk(clk), .rst_n(rst_n), .force_trig(force_trig),
		.sample_time_count(sample_time_count), .smp(smp), .conv(conv));
	function automatic logic [31:0] expv(input afx_row_t r);
		logic [31:0] s;
		s = {20'h0, r.v} << nlog[r.ratio];
		if (r.mode) begin
			return r.res16 ? {16'h0, r.v, 4'h0} : {20'h0, r.v};
		end
		return s >> (nlog[r.ratio] - nlog[r.ratio] / 2);
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rdat = reg_rdata;
	endtask
	task automatic trig(input logic [7:0] m);
		@(posedge clk);
		in_trig <= m;
		@(posedge clk);
		in_trig <= 8'h00;
		#1;
	endtask
	// bounded wait so a stuck burst cannot hang the run
	task automatic wait_ft(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		while ((force_trig & m) !== v && n < 2000) begin
			@(posedge clk);
			#1 n++;
		end
		chk("burst wait", {24'h0, force_trig & m}, {24'h0, v});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		mismatches++;
		print_verdict;
	end
	initial begin
		rows = '{'{3'h0, 1'b0, 1'b0, 1'b1, 12'h123}, '{3'h1, 1'b0, 1'b0, 1'b1, 12'h456},
			'{3'h2, 1'b0, 1'b0, 1'b1, 12'h789}, '{3'h3, 1'b0, 1'b0, 1'b1, 12'hfff},
			'{3'h4, 1'b0, 1'b0, 1'b1, 12'habc}, '{3'h5, 1'b0, 1'b0, 1'b1, 12'h001},
			'{3'h6, 1'b0, 1'b0, 1'b1, 12'h800}, '{3'h7, 1'b0, 1'b0, 1'b1, 12'h5a5},
			'{3'h1, 1'b1, 1'b0, 1'b1, 12'h3c3}, '{3'h0, 1'b1, 1'b1, 1'b0, 12'habc}};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wr(AFX_OFS_CTL2, 32'h0001_0000);
		wr(AFX_OFS_GCFG, 32'h0000_0001);
		rd(AFX_OFS_CTL2);
		chk("control two", rdat, 32'h0001_0000);
		foreach (rows[i]) begin
			w = {1'b1, rows[i].res16, rows[i].mode, rows[i].ratio, rows[i].girq, 9'h000, 16'h0000};
			smp <= rows[i].v;
			wr(AFX_OFS_FILT0, w);
			trig(8'h01);
			chk("burst start", {24'h0, force_trig}, 32'h1);
			wait_ft(8'h01, 8'h00);
			chk("irq", {31'h0, global_irq_evt}, {31'h0, rows[i].girq});
			rd(AFX_OFS_FILT0);
			chk("filter word", rdat, w | 32'h0100_0000 | expv(rows[i]));
			rd(AFX_OFS_FILT0);
			chk("ready clear", rdat & 32'h0100_0000, 32'h0);
		end
		smp <= 12'h100;
		wr(AFX_OFS_FILT1, 32'h8201_0000);
		wr(AFX_OFS_FILT0, 32'h8200_0000);
		trig(8'h03);
		chk("first burst", {24'h0, force_trig}, 32'h1);
		chk("held inputs", {24'h0, hold_shared}, 32'hfe);
		wait_ft(8'h02, 8'h02);
		wait_ft(8'h02, 8'h00);
		rd(AFX_OFS_FILT1);
		chk("second filter", rdat, 32'h8301_0200);
		wr(AFX_OFS_FILT0, 32'h8c00_0000);
		trig(8'h01);
		repeat (10) @(posedge clk);
		wr(AFX_OFS_FILT0, 32'h0000_0000);
		@(posedge clk);
		#1 chk("abort", {24'h0, force_trig}, 32'h0);
		rd(AFX_OFS_FILT0);
		chk("kept result", rdat & 32'h0000_ffff, 32'h200);
		wr(AFX_OFS_FILT0, 32'h8008_0000);
		trig(8'hff);
		chk("no select above 7", {24'h0, force_trig & 8'hfd}, 32'h0);
		rd(8'h10);
		chk("unmapped", rdat, 32'h0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("reset trig", {24'h0, force_trig}, 32'h0);
		rd(AFX_OFS_FILT1);
		chk("reset word", rdat, 32'h0);
		print_verdict;
	end
endmodule
`default_nettype wire
